//--- rtl/palette_pkg.sv
// Shared types, select codes, reset values and timing counts for the palette and clock port.
package palette_pkg;

    // ==========================================================
    // Types
    typedef logic [7:0] byte_t;
    typedef logic [2:0] sel_t;
    typedef logic [15:0] word_t;
    typedef logic [23:0] rgb_t;
    typedef enum logic [1:0] {COMP_RED, COMP_GREEN, COMP_BLUE} comp_t;

    // ==========================================================
    // Register select codes, {reg_select_bit2, reg_select_bit1, reg_select_bit0}
    localparam sel_t SEL_PAL_WIDX = 3'h0;
    localparam sel_t SEL_COLOUR = 3'h1;
    localparam sel_t SEL_MASK = 3'h2;
    localparam sel_t SEL_PAL_RIDX = 3'h3;
    localparam sel_t SEL_PLL_WIDX = 3'h4;
    localparam sel_t SEL_PLL_PARAM = 3'h5;
    localparam sel_t SEL_MODE = 3'h6;
    localparam sel_t SEL_PLL_RIDX = 3'h7;

    // ==========================================================
    // Reset values and field positions
    localparam byte_t MODE_RESET = 8'h00;
    localparam byte_t MASK_RESET = 8'hFF;
    localparam byte_t INDEX_RESET = 8'h00;
    localparam word_t PLL_RESET = 16'h0000;
    localparam int MODE_FIELD_LSB = 5;
    localparam int POWER_DOWN_BIT = 0;

    // ==========================================================
    // Clock parameter bank layout
    localparam logic [4:0] PLL_BANK_PAGE = 5'h01;
    localparam byte_t PLL_SINGLE_INDEX = 8'h0E;
    localparam logic [2:0] PLL_MEMORY_SLOT = 3'h2;
    localparam int PLL_SLOTS = 8;

    // ==========================================================
    // Counts
    localparam int HIDDEN_READS = 4;
    localparam int PIX_DIV = 4;
    localparam int ACCESS_GAP = 2 * PIX_DIV + 2;

    // Bank indices are 08..0F; everything else is a hole that reads as zero.
    function automatic logic is_pll_slot(input byte_t idx);
        return idx[7:3] == PLL_BANK_PAGE;
    endfunction

endpackage

//--- rtl/palette_link_if.sv
// Parallel register-select link between the host end and the palette and clock device.
`timescale 1ns/1ns
interface palette_link_if (
    input wire logic REF_CLK // System clock.
);
    import palette_pkg::*;

    logic reg_select_bit0;
    logic reg_select_bit1;
    logic reg_select_bit2;
    logic rd_req;
    logic wr_req;
    byte_t host_d;
    logic host_oe;
    byte_t dev_d;
    logic dev_oe;
    byte_t data;

    // Resolved level of the shared data bus; an undriven bus reads as zero.
    assign data = dev_oe ? dev_d : (host_oe ? host_d : 8'h00);

    modport device (
        input reg_select_bit0, reg_select_bit1, reg_select_bit2,
        input rd_req, wr_req, data,
        output dev_d, dev_oe
    );

    modport host (
        output reg_select_bit0, reg_select_bit1, reg_select_bit2,
        output rd_req, wr_req, host_d, host_oe,
        input data
    );
endinterface

//--- rtl/palette_ram.sv
// Colour palette store with one write port and two registered read ports.
`timescale 1ns/1ns
module palette_ram #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 24
) (
    input wire logic clk, // System clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic we, // Write strobe.
    input wire logic [ADDR_W-1:0] waddr, // Write address.
    input wire logic [DATA_W-1:0] wdata, // Write data.
    input wire logic [ADDR_W-1:0] raddr_a, // Host fetch address.
    output logic [DATA_W-1:0] rdata_a, // Host fetch data.
    input wire logic [ADDR_W-1:0] raddr_b, // Pixel lookup address.
    output logic [DATA_W-1:0] rdata_b // Pixel lookup data.
);
    logic [DATA_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            rdata_a <= '0;
            rdata_b <= '0;
        end
        else
        begin
            rdata_a <= mem[raddr_a];
            rdata_b <= mem[raddr_b];
        end
    end
endmodule

//--- rtl/palette_pll_device.sv
// Palette DAC and clock synthesizer register port, device end.
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
module palette_pll_device #(
    parameter int DIVIDE = palette_pkg::PIX_DIV
) (
    input wire logic REF_CLK, // System clock, 100 MHz.
    input wire logic RST_N, // Synchronous reset, active low.
    palette_link_if.device link, // Register-select link to the host.
    input wire palette_pkg::byte_t PIXEL_INDEX, // Pixel index from video memory.
    output palette_pkg::rgb_t RGB_OUT, // Looked-up colour, red in the top byte.
    output palette_pkg::byte_t MODE_CONTROL, // Colour mode and power-down bits.
    output logic HIDDEN_FLAG, // Mode register redirection is armed.
    input wire logic [2:0] VIDEO_SEL, // Selected video clock slot.
    output palette_pkg::word_t VIDEO_CLK_PARAM, // Parameter word of the selected slot.
    output palette_pkg::word_t MEMORY_CLK_PARAM // Parameter word of the memory clock.
);
    import palette_pkg::*;

    // ==========================================================
    // Pixel rate enable
    logic [7:0] div_cnt;
    wire pix_en = div_cnt == 8'h00;

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N || div_cnt == 8'(DIVIDE - 1))
            div_cnt <= 8'h00;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // ==========================================================
    // Select decode
    logic hidden_flag;
    logic [1:0] mask_reads;
    wire sel_t sel = {link.reg_select_bit2, link.reg_select_bit1, link.reg_select_bit0};
    wire rd = link.rd_req;
    wire wr = link.wr_req;
    wire access = rd | wr;
    wire mask_hit = sel == SEL_MASK;
    wire to_mode = sel == SEL_MODE || (mask_hit && hidden_flag);
    wire to_mask = mask_hit && !hidden_flag;
    wire wr_widx = wr && sel == SEL_PAL_WIDX;
    wire wr_ridx = wr && sel == SEL_PAL_RIDX;
    wire colour_acc = access && sel == SEL_COLOUR;
    wire pll_idx_wr = wr && (sel == SEL_PLL_WIDX || sel == SEL_PLL_RIDX);
    wire param_acc = access && sel == SEL_PLL_PARAM;
    wire last_read = hidden_flag == 1'b0 && mask_reads == 2'(HIDDEN_READS - 1);

    assign HIDDEN_FLAG = hidden_flag;

    // ==========================================================
    // Hidden flag sequencing
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            hidden_flag <= 1'b0;
            mask_reads <= 2'h0;
        end
        else if (access)
        begin
            if (rd && to_mask)
            begin
                hidden_flag <= last_read;
                mask_reads <= last_read ? 2'h0 : mask_reads + 2'h1;
            end
            else
            begin
                hidden_flag <= 1'b0;
                mask_reads <= 2'h0;
            end
        end
    end

    // ==========================================================
    // Mode register, taken at once
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            MODE_CONTROL <= MODE_RESET;
        else if (wr && to_mode)
            MODE_CONTROL <= link.data;
    end

    // ==========================================================
    // Palette index, triplet and pending transfers
    byte_t widx, ridx, red_h, green_h, fetch_addr, wr_addr, mask, mask_new;
    rgb_t hold, wr_data, ram_a, ram_b;
    comp_t comp;
    logic pend_wr, pend_fetch, mask_pend, busy_q;
    // A transfer runs only on a pixel enable in a gap: no access now or just before,
    // so the fetch address has had a full cycle to reach the store.
    wire xfer_ok = pix_en && !access && !busy_q;
    wire ram_we = xfer_ok && pend_wr;
    wire fetch_ok = xfer_ok && pend_fetch && !pend_wr;
    wire byte_t colour_byte = comp == COMP_RED ? hold[23:16] :
                              comp == COMP_GREEN ? hold[15:8] : hold[7:0];

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            widx <= INDEX_RESET;
            ridx <= INDEX_RESET;
            fetch_addr <= INDEX_RESET;
            wr_addr <= INDEX_RESET;
            red_h <= 8'h00;
            green_h <= 8'h00;
            wr_data <= '0;
            hold <= '0;
            comp <= COMP_RED;
            pend_wr <= 1'b0;
            pend_fetch <= 1'b0;
            busy_q <= 1'b0;
        end
        else
        begin
            busy_q <= access;
            if (ram_we)
                pend_wr <= 1'b0;
            if (fetch_ok)
            begin
                hold <= ram_a;
                pend_fetch <= 1'b0;
            end
            if (wr_widx)
            begin
                widx <= link.data;
                comp <= COMP_RED;
            end
            else if (wr_ridx)
            begin
                fetch_addr <= link.data;
                ridx <= link.data + 8'h01;
                pend_fetch <= 1'b1;
                comp <= COMP_RED;
            end
            else if (colour_acc && comp != COMP_BLUE)
            begin
                if (wr && comp == COMP_RED)
                    red_h <= link.data;
                if (wr && comp == COMP_GREEN)
                    green_h <= link.data;
                comp <= comp == COMP_RED ? COMP_GREEN : COMP_BLUE;
            end
            else if (colour_acc)
            begin
                comp <= COMP_RED;
                if (wr)
                begin
                    wr_data <= {red_h, green_h, link.data};
                    wr_addr <= widx;
                    widx <= widx + 8'h01;
                    pend_wr <= 1'b1;
                end
                else
                begin
                    fetch_addr <= ridx;
                    ridx <= ridx + 8'h01;
                    pend_fetch <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // Pixel mask, applied on a pixel enable; untouched by palette index traffic
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            mask <= MASK_RESET;
            mask_new <= MASK_RESET;
            mask_pend <= 1'b0;
        end
        else if (wr && to_mask)
        begin
            mask_new <= link.data;
            mask_pend <= 1'b1;
        end
        else if (xfer_ok && mask_pend)
        begin
            mask <= mask_new;
            mask_pend <= 1'b0;
        end
    end

    palette_ram #(.ADDR_W(8), .DATA_W(24)) u_ram (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .we(ram_we),
        .waddr(wr_addr),
        .wdata(wr_data),
        .raddr_a(fetch_addr),
        .rdata_a(ram_a),
        .raddr_b(PIXEL_INDEX & mask),
        .rdata_b(ram_b)
    );

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
            RGB_OUT <= '0;
        else if (pix_en)
            RGB_OUT <= ram_b;
    end

    // ==========================================================
    // Clock parameter bank
    byte_t pll_idx, pll_lo;
    logic pll_phase;
    word_t bank [PLL_SLOTS];
    wire [2:0] slot = pll_idx[2:0];
    wire slot_ok = is_pll_slot(pll_idx);
    wire single = pll_idx == PLL_SINGLE_INDEX;
    wire step_done = single || pll_phase;
    wire byte_t pll_byte = !slot_ok ? 8'h00 : (pll_phase && !single) ? bank[slot][15:8] :
                           bank[slot][7:0];

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            pll_idx <= INDEX_RESET;
            pll_lo <= 8'h00;
            pll_phase <= 1'b0;
            for (int i = 0; i < PLL_SLOTS; i++)
                bank[i] <= PLL_RESET;
        end
        else if (pll_idx_wr)
        begin
            pll_idx <= link.data;
            pll_phase <= 1'b0;
        end
        else if (param_acc)
        begin
            pll_phase <= !step_done;
            if (step_done)
                pll_idx <= pll_idx + 8'h01;
            if (wr && !step_done)
                pll_lo <= link.data;
            if (wr && slot_ok && single)
                bank[slot][7:0] <= link.data;
            if (wr && slot_ok && !single && pll_phase)
                bank[slot] <= {link.data, pll_lo};
        end
    end

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            VIDEO_CLK_PARAM <= PLL_RESET;
            MEMORY_CLK_PARAM <= PLL_RESET;
        end
        else
        begin
            VIDEO_CLK_PARAM <= bank[VIDEO_SEL];
            MEMORY_CLK_PARAM <= bank[PLL_MEMORY_SLOT];
        end
    end

    // ==========================================================
    // Read data, driven for the one cycle after the read strobe
    wire byte_t rd_value = to_mode ? MODE_CONTROL :
                           mask_hit ? mask_new :
                           sel == SEL_PAL_WIDX ? widx :
                           sel == SEL_PAL_RIDX ? ridx :
                           sel == SEL_COLOUR ? colour_byte :
                           sel == SEL_PLL_PARAM ? pll_byte : pll_idx;

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            link.dev_d <= 8'h00;
            link.dev_oe <= 1'b0;
        end
        else
        begin
            link.dev_d <= rd ? rd_value : 8'h00;
            link.dev_oe <= rd;
        end
    end
endmodule

//--- rtl/palette_pll_host.sv
// Host end: turns Wishbone register requests into spaced accesses on the select link.
`timescale 1ns/1ns
module palette_pll_host #(
    parameter bit HAS_SEL2 = 1'b1,
    parameter int GAP = palette_pkg::ACCESS_GAP
) (
    input wire logic REF_CLK, // System clock, 100 MHz.
    input wire logic RST_N, // Synchronous reset, active low.
    palette_link_if.host link, // Register-select link to the device.
    input wire logic CYC, // Bus cycle in progress.
    input wire logic STB, // Request strobe, raised with the cycle.
    input wire logic WE, // One for write, zero for read.
    input wire palette_pkg::sel_t ADR, // Target register select code.
    input wire logic SEL, // Byte lane; a write with it low reaches no register.
    input wire palette_pkg::byte_t WDAT, // Write data.
    output palette_pkg::byte_t RDAT, // Read data, held until the next read.
    output logic ACK // Acknowledge, one-cycle pulse.
);
    import palette_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_UNLOCK, H_ACCESS, H_CAPTURE, H_GAP} hstate_t;

    hstate_t state;
    logic cur_write, cur_lane, hidden, pending;
    sel_t cur_sel;
    byte_t cur_data, gap_cnt;
    logic [2:0] unlock_cnt;

    // Without the third select line the mode register is reached through the mask
    // address once the flag has been armed by a burst of mask reads.
    wire sel_t eff_sel = hidden ? SEL_MASK : cur_sel;
    wire sel_t drive_sel = state == H_UNLOCK ? SEL_MASK : eff_sel;
    wire gap_done = gap_cnt == 8'(GAP - 1);

    assign link.rd_req = state == H_UNLOCK || (state == H_ACCESS && !cur_write);
    assign link.wr_req = state == H_ACCESS && cur_write && cur_lane;
    assign link.host_oe = link.wr_req;
    assign link.host_d = cur_data;
    assign link.reg_select_bit0 = drive_sel[0];
    assign link.reg_select_bit1 = drive_sel[1];
    assign link.reg_select_bit2 = HAS_SEL2 ? drive_sel[2] : 1'b0;

    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            state <= H_IDLE;
            cur_write <= 1'b0;
            cur_lane <= 1'b0;
            cur_sel <= SEL_PAL_WIDX;
            cur_data <= 8'h00;
            hidden <= 1'b0;
            pending <= 1'b0;
            unlock_cnt <= 3'h0;
            gap_cnt <= 8'h00;
            ACK <= 1'b0;
            RDAT <= 8'h00;
        end
        else
        begin
            ACK <= 1'b0;
            case (state)
                H_IDLE:
                begin
                    if (CYC && STB)
                    begin
                        cur_write <= WE;
                        cur_lane <= SEL;
                        cur_sel <= ADR;
                        cur_data <= WDAT;
                        pending <= 1'b1;
                        unlock_cnt <= 3'h0;
                        hidden <= !HAS_SEL2 && ADR == SEL_MODE;
                        state <= (!HAS_SEL2 && ADR == SEL_MODE) ? H_UNLOCK : H_ACCESS;
                    end
                end
                H_UNLOCK:
                begin
                    unlock_cnt <= unlock_cnt + 3'h1;
                    gap_cnt <= 8'h00;
                    state <= H_GAP;
                end
                H_ACCESS:
                begin
                    pending <= 1'b0;
                    gap_cnt <= 8'h00;
                    ACK <= cur_write;
                    state <= cur_write ? H_GAP : H_CAPTURE;
                end
                H_CAPTURE:
                begin
                    RDAT <= link.data;
                    ACK <= 1'b1;
                    state <= H_GAP;
                end
                H_GAP:
                begin
                    gap_cnt <= gap_cnt + 8'h01;
                    if (gap_done && !pending)
                        state <= H_IDLE;
                    else if (gap_done && hidden && unlock_cnt != 3'(HIDDEN_READS))
                        state <= H_UNLOCK;
                    else if (gap_done)
                        state <= H_ACCESS;
                end
                default:
                    state <= H_IDLE;
            endcase
        end
    end
endmodule

//--- testbench/palette_pll_checker.sv
// Concurrent checks on the register-select link between the two ends.
`timescale 1ns/1ns
module palette_pll_checker (
    input wire logic REF_CLK, // Clock.
    input wire logic RST_N, // Reset, active low.
    input wire logic reg_select_bit0, // Select.
    input wire logic reg_select_bit1, // Select.
    input wire logic reg_select_bit2, // Select.
    input wire logic rd_req, // Read strobe.
    input wire logic wr_req, // Write strobe.
    input wire palette_pkg::byte_t host_d, // Host data.
    input wire logic host_oe, // Host enable.
    input wire palette_pkg::byte_t dev_d, // Device data.
    input wire logic dev_oe, // Device enable.
    input wire palette_pkg::byte_t data // Bus level.
);
    import palette_pkg::*;

    // ==========================================================
    // Helper logic
    sel_t sel;
    logic strobe;
    logic idx_load;
    logic idx_fresh;
    byte_t idx_last;
    assign sel = {reg_select_bit2, reg_select_bit1, reg_select_bit0};
    assign strobe = rd_req | wr_req;
    assign idx_load = wr_req && (sel == SEL_PLL_WIDX || sel == SEL_PLL_RIDX);

    // Only a read right after an index load can be predicted without a model.
    always_ff @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            idx_fresh <= 1'b0;
            idx_last <= 8'h00;
        end
        else
        begin
            if (strobe)
                idx_fresh <= idx_load;
            if (idx_load)
                idx_last <= host_d;
        end
    end

    // ==========================================================
    // Properties
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_N);

    sequence s_answer;
        ##1 dev_oe ##1 !dev_oe;
    endsequence
    sequence s_quiet;
        !strobe [*8] ##1 !strobe [*2];
    endsequence

    property p_read_answer;
        rd_req |-> s_answer;
    endproperty
    property p_answer_cause;
        dev_oe |-> $past(rd_req);
    endproperty
    property p_exclusive;
        !(rd_req && wr_req);
    endproperty
    property p_spacing;
        strobe |=> s_quiet;
    endproperty
    property p_host_drive;
        wr_req |-> host_oe && data == host_d;
    endproperty
    property p_bus_read;
        dev_oe |-> !host_oe && data == dev_d;
    endproperty
    property p_host_quiet;
        dev_oe |-> !strobe;
    endproperty
    property p_pll_index;
        rd_req && idx_fresh && (sel == SEL_PLL_WIDX || sel == SEL_PLL_RIDX) |=> dev_d == idx_last;
    endproperty

    a_read_answer: assert property (p_read_answer) else $error("read not answered");
    a_answer_cause: assert property (p_answer_cause) else $error("answer without read");
    a_exclusive: assert property (p_exclusive) else $error("read and write together");
    a_spacing: assert property (p_spacing) else $error("accesses too close");
    a_host_drive: assert property (p_host_drive) else $error("write data not on bus");
    a_bus_read: assert property (p_bus_read) else $error("read data not on bus");
    a_host_quiet: assert property (p_host_quiet) else $error("request during read answer");
    a_pll_index: assert property (p_pll_index) else $error("clock index readback");
endmodule

//--- testbench/palette_pll_host_interface_bench.sv
// Self-checking bench joining the host and device ends of the palette and clock port.
`timescale 1ns/1ns
module palette_pll_host_interface_bench;
    import palette_pkg::*;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic sel = 1'b0;
    sel_t adr = 3'h0;
    byte_t wdat = 8'h00;
    byte_t rdat;
    logic ack;
    byte_t pix = 8'hFF;
    logic [2:0] vsel = 3'h3;
    rgb_t rgb;
    byte_t mode;
    logic flag;
    word_t vparam;
    word_t mparam;
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;

    always #5 clk = ~clk;

    // ==========================================================
    // Ends, link and checker
    palette_link_if link (.REF_CLK(clk));
    palette_pll_host palette_pll_host_inst (.REF_CLK(clk), .RST_N(rst_n), .link(link.host),
        .CYC(cyc), .STB(stb), .WE(we), .ADR(adr), .SEL(sel), .WDAT(wdat), .RDAT(rdat),
        .ACK(ack));
    palette_pll_device palette_pll_device_inst (.REF_CLK(clk), .RST_N(rst_n),
        .link(link.device), .PIXEL_INDEX(pix), .RGB_OUT(rgb), .MODE_CONTROL(mode),
        .HIDDEN_FLAG(flag), .VIDEO_SEL(vsel), .VIDEO_CLK_PARAM(vparam),
        .MEMORY_CLK_PARAM(mparam));
    palette_pll_checker palette_pll_checker_inst (.REF_CLK(clk), .RST_N(rst_n),
        .reg_select_bit0(link.reg_select_bit0), .reg_select_bit1(link.reg_select_bit1),
        .reg_select_bit2(link.reg_select_bit2), .rd_req(link.rd_req), .wr_req(link.wr_req),
        .host_d(link.host_d), .host_oe(link.host_oe), .dev_d(link.dev_d),
        .dev_oe(link.dev_oe), .data(link.data));

    // ==========================================================
    // Tasks
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Lets outputs launched at the last edge settle before they are compared.
    task automatic idle();
        @(negedge clk);
    endtask

    // Classic single cycle: the request rises after an edge and is held until ack is
    // sampled high at a rising edge; read data is taken there, then the bus is released.
    task automatic access(input logic w, input sel_t a, input byte_t d, input logic l,
                          output byte_t q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= l;
        adr <= a;
        wdat <= d;
        do
            @(posedge clk);
        while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input sel_t s, input byte_t d);
        byte_t q;
        access(1'b1, s, d, 1'b1, q);
    endtask

    task automatic rd(input sel_t s, input byte_t exp, input string what);
        byte_t q;
        access(1'b0, s, 8'h00, 1'b1, q);
        chk(what, q, exp);
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hang is cut short well past the thousand or so cycles the tests need.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ==========================================================
    // Tests
    initial
    begin
        byte_t q;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        idle();
        chk("mode", mode, MODE_RESET);
        chk("flag", flag, 1'b0);
        chk("mparam", mparam, PLL_RESET);
        rd(SEL_MASK, MASK_RESET, "mask");
        $display("Done: reset");
        wr(SEL_PAL_WIDX, 8'h10);
        for (int i = 1; i < 7; i++)
            wr(SEL_COLOUR, 8'(8'h11 * i));
        rd(SEL_PAL_WIDX, 8'h12, "widx");
        wr(SEL_PAL_RIDX, 8'h10);
        for (int i = 1; i < 7; i++)
            rd(SEL_COLOUR, 8'(8'h11 * i), "colour");
        rd(SEL_PAL_RIDX, 8'h13, "ridx");
        $display("Done: palette");
        wr(SEL_PAL_WIDX, 8'hFF);
        wr(SEL_COLOUR, 8'hAA);
        wr(SEL_COLOUR, 8'hBB);
        wr(SEL_PAL_WIDX, 8'hFF);
        for (int i = 1; i < 4; i++)
            wr(SEL_COLOUR, 8'(i));
        rd(SEL_PAL_WIDX, 8'h00, "widx wrap");
        wr(SEL_PAL_RIDX, 8'hFF);
        rd(SEL_COLOUR, 8'h01, "red");
        wr(SEL_PAL_RIDX, 8'hFF);
        for (int i = 1; i < 4; i++)
            rd(SEL_COLOUR, 8'(i), "restart");
        $display("Done: abort");
        wr(SEL_PAL_WIDX, 8'h0F);
        for (int i = 0; i < 3; i++)
            wr(SEL_COLOUR, 8'(8'h0A + i));
        wr(SEL_MASK, 8'h0F);
        rd(SEL_PAL_WIDX, 8'h10, "widx");
        repeat (40)
        begin
            @(negedge clk);
            if (rgb === 24'h0A0B0C)
                break;
        end
        chk("rgb", rgb, 24'h0A0B0C);
        $display("Done: mask");
        wr(SEL_MODE, 8'h40);
        idle();
        chk("mode", mode, 8'h40);
        repeat (4) rd(SEL_MASK, 8'h0F, "mask");
        chk("flag", flag, 1'b1);
        wr(SEL_MASK, 8'h20);
        idle();
        chk("mode", mode, 8'h20);
        chk("flag", flag, 1'b0);
        repeat (3) rd(SEL_MASK, 8'h0F, "mask");
        rd(SEL_PAL_WIDX, 8'h10, "widx");
        rd(SEL_MASK, 8'h0F, "mask");
        chk("flag", flag, 1'b0);
        rd(SEL_MODE, 8'h20, "mode");
        access(1'b1, SEL_MODE, 8'h99, 1'b0, q);
        idle();
        chk("mode", mode, 8'h20);
        $display("Done: hidden");
        wr(SEL_PLL_WIDX, 8'h0A);
        wr(SEL_PLL_PARAM, 8'h34);
        idle();
        chk("mparam", mparam, 16'h0000);
        wr(SEL_PLL_PARAM, 8'h12);
        idle();
        chk("mparam", mparam, 16'h1234);
        rd(SEL_PLL_RIDX, 8'h0B, "cidx");
        wr(SEL_PLL_PARAM, 8'hEF);
        wr(SEL_PLL_RIDX, 8'h0B);
        wr(SEL_PLL_PARAM, 8'h78);
        idle();
        chk("vparam", vparam, 16'h0000);
        wr(SEL_PLL_PARAM, 8'h56);
        idle();
        chk("vparam", vparam, 16'h5678);
        @(posedge clk);
        vsel <= 3'h2;
        repeat (2) idle();
        chk("vparam", vparam, 16'h1234);
        wr(SEL_PLL_WIDX, 8'h0E);
        wr(SEL_PLL_PARAM, 8'h9A);
        rd(SEL_PLL_WIDX, 8'h0F, "cidx");
        wr(SEL_PLL_WIDX, 8'h0A);
        rd(SEL_PLL_PARAM, 8'h34, "byte1");
        rd(SEL_PLL_PARAM, 8'h12, "byte2");
        rd(SEL_PLL_RIDX, 8'h0B, "cidx");
        wr(SEL_PLL_WIDX, 8'h0E);
        rd(SEL_PLL_PARAM, 8'h9A, "single");
        rd(SEL_PLL_WIDX, 8'h0F, "cidx");
        wr(SEL_PLL_WIDX, 8'hFF);
        rd(SEL_PLL_RIDX, 8'hFF, "cidx");
        wr(SEL_PLL_PARAM, 8'h00);
        wr(SEL_PLL_PARAM, 8'h00);
        rd(SEL_PLL_WIDX, 8'h00, "cidx wrap");
        $display("Done: clock");
        end_of_test();
    end
endmodule
